// File: ixs_pkg.sv
// ixs_pkg: shared constants for the extended swap/skip/table/xor executor
// assumes: one core clock, sequencer and memories on the same clock
package ixs_pkg;

  // ----------------------------------------------------------------
  // operation codes presented by the sequencer
  // ----------------------------------------------------------------
  localparam int OP_W = 4;
  typedef enum logic [OP_W-1:0] {
    IXS_OP_NIBBLE_EXCHANGE_IN_PLACE      = 4'h0,
    IXS_OP_NIBBLE_EXCHANGE_TO_ACCUM      = 4'h1,
    IXS_OP_SKIP_WHEN_NULL                = 4'h2,
    IXS_OP_COPY_AND_SKIP_WHEN_NULL       = 4'h3,
    IXS_OP_SKIP_WHEN_BIT_NULL            = 4'h4,
    IXS_OP_PAGE_TABLE_FETCH              = 4'h5,
    IXS_OP_FINAL_PAGE_TABLE_FETCH        = 4'h6,
    IXS_OP_PREINC_PAGE_TABLE_FETCH       = 4'h7,
    IXS_OP_PREINC_FINAL_PAGE_TABLE_FETCH = 4'h8,
    IXS_OP_EXCLUSIVE_OR_TO_ACCUM         = 4'h9,
    IXS_OP_EXCLUSIVE_OR_TO_MEMORY        = 4'hA
  } ixs_op_e;

  // ----------------------------------------------------------------
  // executor states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IXS_ST_IDLE  = 4'b0001,
    IXS_ST_DREAD = 4'b0010,
    IXS_ST_PREAD = 4'b0100,
    IXS_ST_DUMMY = 4'b1000
  } ixs_state_e;

  // ----------------------------------------------------------------
  // register port map and field layout
  // ----------------------------------------------------------------
  localparam int REG_AW = 3;
  localparam int DATA_W = 8;
  localparam logic [REG_AW-1:0] REG_ACCUM       = 3'h0;
  localparam logic [REG_AW-1:0] REG_STATUS      = 3'h1;
  localparam logic [REG_AW-1:0] REG_TBL_LOWER   = 3'h2;
  localparam logic [REG_AW-1:0] REG_TBL_UPPER   = 3'h3;
  localparam logic [REG_AW-1:0] REG_TBL_LATCH   = 3'h4;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] NULL_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam int NIB_W = 4;

endpackage

// File: ixs_exec.sv
// ixs_exec: executes the extended nibble swap, skip-if-zero, table read
// and xor instructions on behalf of the core sequencer
// assumes: data and program memories answer a read in the same cycle as its read strobe,
// sequencer issues one instruction at a time while busy is low
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE1] In-place nibble exchange swaps the two halves of the byte, writes it back and changes no flag.
// [RULE2] Nibble exchange to accumulator puts the high nibble in acc 3..0 and the low one in acc 7..4, memory and flags untouched.
// [RULE3] Skip-when-null reads the byte, writes the same value back and skips the next instruction when it is zero.
// [RULE4] A taken skip inserts one dummy slot so that it spans three instruction cycles.
// [RULE5] Copy-and-skip loads the byte into the accumulator and skips when the loaded value is zero.
// [RULE6] Bit skip skips the next instruction when the selected bit is zero and changes no flag.
// [RULE7] Page table fetch reads the word at upper:lower pointer, low byte to memory and high byte to the latch.
// [RULE8] Final page table fetch reads the word in the last page at the lower pointer offset alone.
// [RULE9] Pre-increment page fetch bumps the lower pointer and then performs the page fetch with it.
// [RULE10] Pre-increment final page fetch bumps the lower pointer and then reads the last page at that offset.
// [RULE11] Xor to accumulator stores acc xor byte into the accumulator and updates only the zero flag.
// [RULE12] Xor to memory stores acc xor byte back into the byte and updates only the zero flag.
// [RULE13] The lower pointer increment wraps in eight bits and never carries into the upper pointer.
module ixs_exec #(
  parameter int PM_AW = 12,
  parameter int PM_DW = 16,
  parameter int DM_AW = 8
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST,
  // sequencer side
  input  wire logic                       EXE_START,
  input  wire ixs_pkg::ixs_op_e           EXE_OP,
  input  wire logic [DM_AW-1:0]           EXE_ADDR,
  input  wire logic [2:0]                 EXE_BIT,
  output logic                            EXE_BUSY,
  output logic                            EXE_DONE,
  output logic                            EXE_SKIP,
  output logic                            DUMMY_SLOT,
  // data memory port
  output logic [DM_AW-1:0]                DM_ADDR,
  output logic                            DM_RD,
  output logic                            DM_WR,
  output logic [ixs_pkg::DATA_W-1:0]      DM_WDATA,
  input  wire logic [ixs_pkg::DATA_W-1:0] DM_RDATA,
  // program memory port
  output logic [PM_AW-1:0]                PM_ADDR,
  output logic                            PM_RD,
  input  wire logic [PM_DW-1:0]           PM_RDATA,
  // core state visible to the rest of the core
  output logic [ixs_pkg::DATA_W-1:0]      ACC_OUT,
  output logic                            ZERO_FLAG,
  output logic [ixs_pkg::DATA_W-1:0]      TABLE_UPPER_BYTE_LATCH,
  // software register port
  input  wire logic [ixs_pkg::REG_AW-1:0] REG_ADDR,
  input  wire logic [ixs_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic [ixs_pkg::DATA_W-1:0]      REG_RDATA
);
  import ixs_pkg::*;

  localparam int HI_W = PM_DW - DATA_W;
  localparam int UP_W = PM_AW - DATA_W;
  localparam logic [UP_W-1:0] LAST_PAGE = {UP_W{1'b1}};

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  ixs_state_e                 state_ff;
  ixs_state_e                 nxt_state;
  ixs_op_e                    op_ff;
  logic [DM_AW-1:0]           addr_ff;
  logic [2:0]                 bit_ff;
  logic [DATA_W-1:0]          acc_ff;
  logic                       zero_ff;
  logic [DATA_W-1:0]          tbl_lower_ff;
  logic [UP_W-1:0]            tbl_upper_ff;
  logic [DATA_W-1:0]          tbl_latch_ff;
  logic                       busy_ff;
  logic                       done_ff;
  logic                       skip_ff;
  logic                       dummy_ff;
  logic [DM_AW-1:0]           dm_addr_ff;
  logic                       dm_rd_ff;
  logic                       dm_wr_ff;
  logic [DATA_W-1:0]          dm_wdata_ff;
  logic [PM_AW-1:0]           pm_addr_ff;
  logic                       pm_rd_ff;
  logic [DATA_W-1:0]          rdata_ff;

  // ----------------------------------------------------------------
  // instruction classification
  // ----------------------------------------------------------------
  wire st_idle  = (state_ff == IXS_ST_IDLE);
  wire st_dread = (state_ff == IXS_ST_DREAD);
  wire st_pread = (state_ff == IXS_ST_PREAD);
  wire st_dummy = (state_ff == IXS_ST_DUMMY);
  wire launch   = st_idle && EXE_START;

  // table class of the incoming op decides which memory is read, program for table ops, data for the rest
  wire in_tbl_page  = (EXE_OP == IXS_OP_PAGE_TABLE_FETCH) ||
                      (EXE_OP == IXS_OP_PREINC_PAGE_TABLE_FETCH);
  wire in_tbl_final = (EXE_OP == IXS_OP_FINAL_PAGE_TABLE_FETCH) ||
                      (EXE_OP == IXS_OP_PREINC_FINAL_PAGE_TABLE_FETCH);
  wire in_preinc    = (EXE_OP == IXS_OP_PREINC_PAGE_TABLE_FETCH) ||
                      (EXE_OP == IXS_OP_PREINC_FINAL_PAGE_TABLE_FETCH);
  wire in_table     = in_tbl_page || in_tbl_final;

  // ----------------------------------------------------------------
  // table address formation
  // ----------------------------------------------------------------
  // [RULE13] eight-bit wrap
  wire [DATA_W-1:0] lower_inc  = tbl_lower_ff + ONE_BYTE;
  // [RULE9] pointer bumped before use
  wire [DATA_W-1:0] lower_use  = in_preinc ? lower_inc : tbl_lower_ff;
  // [RULE7] upper and lower pointers joined
  wire [PM_AW-1:0]  page_addr  = {tbl_upper_ff, lower_use};
  // [RULE8] last page, lower offset only
  wire [PM_AW-1:0]  final_addr = {LAST_PAGE, lower_use};
  // [RULE10] final page with bumped offset
  wire [PM_AW-1:0]  tbl_addr   = in_tbl_final ? final_addr : page_addr;

  // ----------------------------------------------------------------
  // datapath on the byte returned from data memory
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] mem_byte  = DM_RDATA;
  // [RULE1] halves exchanged
  wire [DATA_W-1:0] swapped   = {mem_byte[NIB_W-1:0], mem_byte[DATA_W-1:NIB_W]};
  wire [DATA_W-1:0] xored     = acc_ff ^ mem_byte;
  wire              byte_null = (mem_byte == NULL_BYTE);
  wire              bit_null  = ~mem_byte[bit_ff];
  wire              xor_null  = (xored == NULL_BYTE);

  // per-op effects in the data read cycle
  wire op_swap_mem  = (op_ff == IXS_OP_NIBBLE_EXCHANGE_IN_PLACE);
  wire op_swap_acc  = (op_ff == IXS_OP_NIBBLE_EXCHANGE_TO_ACCUM);
  wire op_skz       = (op_ff == IXS_OP_SKIP_WHEN_NULL);
  wire op_copy_skz  = (op_ff == IXS_OP_COPY_AND_SKIP_WHEN_NULL);
  wire op_bit_skz   = (op_ff == IXS_OP_SKIP_WHEN_BIT_NULL);
  wire op_xor_acc   = (op_ff == IXS_OP_EXCLUSIVE_OR_TO_ACCUM);
  wire op_xor_mem   = (op_ff == IXS_OP_EXCLUSIVE_OR_TO_MEMORY);

  // [RULE3] zero byte skips, [RULE5] on loaded value, [RULE6] on bit
  wire skip_taken = st_dread && ((op_skz && byte_null) || (op_copy_skz && byte_null) ||
                                 (op_bit_skz && bit_null));

  // [RULE3] same value written back; [RULE1] and [RULE12] write results
  wire mem_write  = st_dread && (op_swap_mem || op_skz || op_xor_mem);
  wire [DATA_W-1:0] mem_wval = op_swap_mem ? swapped :
                               op_xor_mem  ? xored   : mem_byte;

  // [RULE2] swap into acc, [RULE5] copy, [RULE11] xor result
  wire acc_load = st_dread && (op_swap_acc || op_copy_skz || op_xor_acc);
  wire [DATA_W-1:0] acc_val = op_swap_acc ? swapped :
                              op_xor_acc  ? xored   : mem_byte;

  // [RULE11] [RULE12] only the xor ops touch the zero flag
  wire zero_load = st_dread && (op_xor_acc || op_xor_mem);

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire wr_acc   = REG_WR && (REG_ADDR == REG_ACCUM);
  wire wr_stat  = REG_WR && (REG_ADDR == REG_STATUS);
  wire wr_lower = REG_WR && (REG_ADDR == REG_TBL_LOWER);
  wire wr_upper = REG_WR && (REG_ADDR == REG_TBL_UPPER);
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    stat_word                = RST_BYTE;
    stat_word[STAT_ZERO_BIT] = zero_ff;
    stat_word[STAT_BUSY_BIT] = busy_ff;
    unique case (REG_ADDR)
      REG_ACCUM:     rd_mux = acc_ff;
      REG_STATUS:    rd_mux = stat_word;
      REG_TBL_LOWER: rd_mux = tbl_lower_ff;
      REG_TBL_UPPER: rd_mux = DATA_W'(tbl_upper_ff);
      REG_TBL_LATCH: rd_mux = tbl_latch_ff;
      default:       rd_mux = RST_BYTE; // unmapped reads as zero
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IXS_ST_IDLE: begin
        if (EXE_START) begin
          nxt_state = in_table ? IXS_ST_PREAD : IXS_ST_DREAD;
        end
      end
      IXS_ST_DREAD: begin
        // [RULE4] taken skip spends one more slot
        nxt_state = skip_taken ? IXS_ST_DUMMY : IXS_ST_IDLE;
      end
      IXS_ST_PREAD: nxt_state = IXS_ST_IDLE;
      IXS_ST_DUMMY: nxt_state = IXS_ST_IDLE;
      default:      nxt_state = IXS_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing registers
  // ----------------------------------------------------------------
  // op latched once so the sequencer may move on its own inputs
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff <= IXS_ST_IDLE;
      op_ff    <= IXS_OP_NIBBLE_EXCHANGE_IN_PLACE;
      addr_ff  <= '0;
      bit_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (launch) begin
        op_ff   <= EXE_OP;
        addr_ff <= EXE_ADDR;
        bit_ff  <= EXE_BIT;
      end
    end
  end

  // handshake outputs, all registered
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      skip_ff  <= 1'b0;
      dummy_ff <= 1'b0;
    end else begin
      busy_ff  <= (nxt_state != IXS_ST_IDLE);
      done_ff  <= (st_dread && !skip_taken) || st_pread || st_dummy;
      skip_ff  <= skip_taken;
      // [RULE4] dummy slot flagged while next fetch is discarded
      dummy_ff <= skip_taken;
    end
  end

  // ----------------------------------------------------------------
  // memory ports
  // ----------------------------------------------------------------
  // data read at launch, write with the result or the table low byte
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dm_addr_ff  <= '0;
      dm_rd_ff    <= 1'b0;
      dm_wr_ff    <= 1'b0;
      dm_wdata_ff <= RST_BYTE;
    end else begin
      dm_rd_ff <= launch && !in_table;
      // [RULE7] low byte stored to the addressed byte
      dm_wr_ff <= mem_write || st_pread;
      if (launch) begin
        dm_addr_ff <= EXE_ADDR;
      end
      if (st_pread) begin
        dm_wdata_ff <= PM_RDATA[DATA_W-1:0];
      end else if (mem_write) begin
        dm_wdata_ff <= mem_wval;
      end
    end
  end

  // program read issued at launch for the four table ops
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pm_addr_ff <= '0;
      pm_rd_ff   <= 1'b0;
    end else begin
      pm_rd_ff <= launch && in_table;
      if (launch && in_table) begin
        pm_addr_ff <= tbl_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  // executor wins over a same-cycle software write; it owns the core
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_ff  <= RST_BYTE;
      zero_ff <= 1'b0;
    end else begin
      if (acc_load) begin
        acc_ff <= acc_val;
      end else if (wr_acc) begin
        acc_ff <= REG_WDATA;
      end
      if (zero_load) begin
        zero_ff <= xor_null;
      end else if (wr_stat) begin
        zero_ff <= REG_WDATA[STAT_ZERO_BIT];
      end
    end
  end

  // table pointers and the high-byte latch
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tbl_lower_ff <= RST_BYTE;
      tbl_upper_ff <= '0;
      tbl_latch_ff <= RST_BYTE;
    end else begin
      // [RULE9] [RULE10] pointer kept incremented
      if (launch && in_preinc) begin
        tbl_lower_ff <= lower_inc;
      end else if (wr_lower) begin
        tbl_lower_ff <= REG_WDATA;
      end
      if (wr_upper) begin
        tbl_upper_ff <= REG_WDATA[UP_W-1:0];
      end
      // [RULE7] [RULE8] high byte into the latch
      if (st_pread) begin
        tbl_latch_ff <= DATA_W'(PM_RDATA[PM_DW-1:DATA_W]);
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= REG_RD ? rd_mux : RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign EXE_BUSY               = busy_ff;
  assign EXE_DONE               = done_ff;
  assign EXE_SKIP               = skip_ff;
  assign DUMMY_SLOT             = dummy_ff;
  assign DM_ADDR                = dm_addr_ff;
  assign DM_RD                  = dm_rd_ff;
  assign DM_WR                  = dm_wr_ff;
  assign DM_WDATA               = dm_wdata_ff;
  assign PM_ADDR                = pm_addr_ff;
  assign PM_RD                  = pm_rd_ff;
  assign ACC_OUT                = acc_ff;
  assign ZERO_FLAG              = zero_ff;
  assign TABLE_UPPER_BYTE_LATCH = tbl_latch_ff;
  assign REG_RDATA              = rdata_ff;

endmodule

`default_nettype wire

// File: ixs_exec_monitor.sv
// ixs_exec_monitor: port-level checks on the swap/skip/table/xor executor
// assumes: bound to ixs_exec, single clock, RST synchronous active high
`timescale 1ns/1ps
`default_nettype none
module ixs_exec_monitor
  import ixs_pkg::*;
#(
  parameter int PM_AW = 12,
  parameter int PM_DW = 16,
  parameter int DM_AW = 8
) (
  input wire logic                       REF_CLK,
  input wire logic                       RST,
  input wire logic                       EXE_START,
  input wire ixs_pkg::ixs_op_e           EXE_OP,
  input wire logic [DM_AW-1:0]           EXE_ADDR,
  input wire logic [2:0]                 EXE_BIT,
  input wire logic                       EXE_BUSY,
  input wire logic                       EXE_DONE,
  input wire logic                       EXE_SKIP,
  input wire logic                       DUMMY_SLOT,
  input wire logic [DM_AW-1:0]           DM_ADDR,
  input wire logic                       DM_RD,
  input wire logic                       DM_WR,
  input wire logic [ixs_pkg::DATA_W-1:0] DM_WDATA,
  input wire logic [ixs_pkg::DATA_W-1:0] DM_RDATA,
  input wire logic [PM_AW-1:0]           PM_ADDR,
  input wire logic                       PM_RD,
  input wire logic [PM_DW-1:0]           PM_RDATA,
  input wire logic [ixs_pkg::DATA_W-1:0] ACC_OUT,
  input wire logic                       ZERO_FLAG,
  input wire logic [ixs_pkg::DATA_W-1:0] TABLE_UPPER_BYTE_LATCH,
  input wire logic [ixs_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [ixs_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic                       REG_WR,
  input wire logic                       REG_RD,
  input wire logic [ixs_pkg::DATA_W-1:0] REG_RDATA
);
  ixs_op_e    op_ff;
  logic [7:0] rd_ff;
  logic [7:0] acc_ff;
  logic [2:0] bit_ff;
  logic [PM_DW-1:0] pm_ff;
  wire logic [7:0] swp = {rd_ff[3:0], rd_ff[7:4]};
  wire logic       fin = (op_ff == IXS_OP_FINAL_PAGE_TABLE_FETCH) || (op_ff == IXS_OP_PREINC_FINAL_PAGE_TABLE_FETCH);

  // operands latched at the accepted start, data at each memory read
  always_ff @(posedge REF_CLK) begin
    if (EXE_START && !EXE_BUSY) begin
      op_ff  <= EXE_OP;
      acc_ff <= ACC_OUT;
      bit_ff <= EXE_BIT;
    end
    if (DM_RD) begin
      rd_ff <= DM_RDATA;
    end
    if (PM_RD) begin
      pm_ff <= PM_RDATA;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  swap_mem_a: assert property (
    DM_WR && op_ff == IXS_OP_NIBBLE_EXCHANGE_IN_PLACE |-> DM_WDATA == swp && $stable(ZERO_FLAG))
    else $error("in-place swap wrote a wrong byte");
  swap_acc_a: assert property (
    EXE_DONE && op_ff == IXS_OP_NIBBLE_EXCHANGE_TO_ACCUM |-> ACC_OUT == swp && !DM_WR)
    else $error("swap to accumulator wrong");
  null_skip_a: assert property (
    DM_WR && op_ff == IXS_OP_SKIP_WHEN_NULL |-> DM_WDATA == rd_ff && EXE_SKIP == (rd_ff == 8'h00))
    else $error("skip when null wrong");
  skip_slot_a: assert property (
    EXE_SKIP |-> DUMMY_SLOT ##1 (EXE_DONE && !EXE_SKIP))
    else $error("taken skip without dummy slot");
  start_done_a: assert property (
    EXE_START && !EXE_BUSY |=> EXE_BUSY ##[1:2] EXE_DONE)
    else $error("instruction did not finish in time");
  copy_skip_a: assert property (
    DM_RD && op_ff == IXS_OP_COPY_AND_SKIP_WHEN_NULL |=> ACC_OUT == rd_ff && EXE_SKIP == (rd_ff == 8'h00))
    else $error("copy and skip wrong");
  bit_skip_a: assert property (
    DM_RD && op_ff == IXS_OP_SKIP_WHEN_BIT_NULL |=> EXE_SKIP == !rd_ff[bit_ff] && $stable(ZERO_FLAG))
    else $error("bit skip wrong");
  table_store_a: assert property (
    PM_RD |=> DM_WR && DM_WDATA == pm_ff[7:0] && TABLE_UPPER_BYTE_LATCH == pm_ff[15:8])
    else $error("table word split wrong");
  last_page_a: assert property (
    PM_RD && fin |-> &PM_ADDR[PM_AW-1:8])
    else $error("last page address wrong");
  xor_acc_a: assert property (
    DM_RD && op_ff == IXS_OP_EXCLUSIVE_OR_TO_ACCUM |=> ACC_OUT == (acc_ff ^ rd_ff) && ZERO_FLAG == (ACC_OUT == 8'h00))
    else $error("xor to accumulator wrong");
  xor_mem_a: assert property (
    DM_WR && op_ff == IXS_OP_EXCLUSIVE_OR_TO_MEMORY |-> DM_WDATA == (acc_ff ^ rd_ff) && ZERO_FLAG == (DM_WDATA == 8'h00))
    else $error("xor to memory wrong");

  skip_seen_c:  cover property (EXE_SKIP);
  table_seen_c: cover property (PM_RD && fin);
  xor_seen_c:   cover property (DM_WR && op_ff == IXS_OP_EXCLUSIVE_OR_TO_MEMORY);
endmodule

bind ixs_exec ixs_exec_monitor #(.PM_AW(PM_AW), .PM_DW(PM_DW), .DM_AW(DM_AW)) ixs_exec_monitor_inst (
  .REF_CLK(REF_CLK), .RST(RST), .EXE_START(EXE_START), .EXE_OP(EXE_OP), .EXE_ADDR(EXE_ADDR),
  .EXE_BIT(EXE_BIT), .EXE_BUSY(EXE_BUSY), .EXE_DONE(EXE_DONE), .EXE_SKIP(EXE_SKIP),
  .DUMMY_SLOT(DUMMY_SLOT), .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_WR(DM_WR), .DM_WDATA(DM_WDATA),
  .DM_RDATA(DM_RDATA), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA), .ACC_OUT(ACC_OUT),
  .ZERO_FLAG(ZERO_FLAG), .TABLE_UPPER_BYTE_LATCH(TABLE_UPPER_BYTE_LATCH), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
`default_nettype wire

// File: ixs_exec_bench.sv
// ixs_exec_bench: directed test of the executor through its own ports
// assumes: memories answer in the cycle their read strobe is high
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ixs_exec_bench;
  import ixs_pkg::*;
  logic ref_clk = 0, rst = 1, exe_start = 0, reg_wr = 0, reg_rd = 0;
  ixs_op_e exe_op = IXS_OP_NIBBLE_EXCHANGE_IN_PLACE;
  logic [7:0] exe_addr = 0, reg_wdata = 0, r, el_e = 0;
  logic [2:0] exe_bit = 0, reg_addr = 0;
  logic exe_busy, exe_done, exe_skip, dummy_slot, dm_rd, dm_wr, pm_rd, zero_flag;
  logic [7:0] dm_addr, dm_wdata, acc_out, tbl_latch, reg_rdata;
  logic [11:0] pm_addr;
  logic [15:0] w;
  logic [7:0] mem [256];
  int failures = 0, checks_done = 0;

  // program image: address-derived so each word is distinct
  // high byte mixes page and offset so every fetched word and half differs
  function automatic logic [15:0] pmw(logic [11:0] a);
    return {a[7:0] ^ a[11:4] ^ 8'h96, a[11:4]};
  endfunction
  // released data lines show the inverse, never the last value
  wire logic [7:0]  dm_rdata = dm_rd ? mem[dm_addr] : ~mem[dm_addr];
  wire logic [15:0] pm_rdata = pm_rd ? pmw(pm_addr) : ~pmw(pm_addr);

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (dm_wr) mem[dm_addr] <= dm_wdata;

  ixs_exec ixs_exec_inst (
    .REF_CLK(ref_clk), .RST(rst), .EXE_START(exe_start), .EXE_OP(exe_op), .EXE_ADDR(exe_addr),
    .EXE_BIT(exe_bit), .EXE_BUSY(exe_busy), .EXE_DONE(exe_done), .EXE_SKIP(exe_skip),
    .DUMMY_SLOT(dummy_slot), .DM_ADDR(dm_addr), .DM_RD(dm_rd), .DM_WR(dm_wr), .DM_WDATA(dm_wdata),
    .DM_RDATA(dm_rdata), .PM_ADDR(pm_addr), .PM_RD(pm_rd), .PM_RDATA(pm_rdata), .ACC_OUT(acc_out),
    .ZERO_FLAG(zero_flag), .TABLE_UPPER_BYTE_LATCH(tbl_latch), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // register port and instruction tasks
  // ----------------------------------------------------------------
  task automatic reg_write(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask

  task automatic reg_read(logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // one instruction; expected byte, acc, zero flag and skip given
  task automatic run(ixs_op_e op, logic [7:0] a, logic [2:0] b, logic [7:0] m0, logic [7:0] em,
                     logic [7:0] ea, logic ez, logic es);
    int n;
    logic sk;
    logic dm;
    mem[a] = m0;
    @(posedge ref_clk);
    exe_start <= 1;
    exe_op <= op;
    exe_addr <= a;
    exe_bit <= b;
    @(posedge ref_clk);
    exe_start <= 0;
    n = 0;
    sk = 0;
    dm = 0;
    do begin
      @(negedge ref_clk);
      n++;
      sk |= exe_skip;
      dm |= dummy_slot;
    end while (exe_done !== 1'b1 && n < 8);
    // a hang counts once here; the run still ends at the closing report
    if (exe_done !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: instruction never completed", $time);
    end
    @(negedge ref_clk);
    `CHK(n, es ? 3 : 2)
    `CHK(sk, es)
    `CHK(dm, es)
    `CHK(mem[a], em)
    `CHK(acc_out, ea)
    `CHK(zero_flag, ez)
    `CHK(tbl_latch, el_e)
  endtask

  // table fetch into byte 20; the word comes from the given program address
  task automatic tfetch(ixs_op_e op, logic [11:0] pa);
    w = pmw(pa);
    el_e = w[15:8];
    run(op, 8'h14, 3'h0, 8'h00, w[7:0], 8'h81, 1'b0, 1'b0);
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'(i);
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    `CHK(acc_out, 8'h00)
    `CHK(tbl_latch, 8'h00)
    reg_read(3'h7, r);
    `CHK(r, 8'h00)
    $display("test reset done");
    run(IXS_OP_NIBBLE_EXCHANGE_IN_PLACE, 8'h0A, 3'h0, 8'h3C, 8'hC3, 8'h00, 1'b0, 1'b0);
    run(IXS_OP_NIBBLE_EXCHANGE_TO_ACCUM, 8'h0B, 3'h0, 8'h5A, 8'h5A, 8'hA5, 1'b0, 1'b0);
    run(IXS_OP_SKIP_WHEN_NULL, 8'h0C, 3'h0, 8'h00, 8'h00, 8'hA5, 1'b0, 1'b1);
    run(IXS_OP_SKIP_WHEN_NULL, 8'h0C, 3'h0, 8'h07, 8'h07, 8'hA5, 1'b0, 1'b0);
    run(IXS_OP_COPY_AND_SKIP_WHEN_NULL, 8'h0D, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    run(IXS_OP_COPY_AND_SKIP_WHEN_NULL, 8'h0D, 3'h0, 8'h81, 8'h81, 8'h81, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      run(IXS_OP_SKIP_WHEN_BIT_NULL, 8'h0E, 3'(i), 8'hA5, 8'hA5, 8'h81, 1'b0, (8'hA5 & (8'h01 << i)) == 8'h00);
    end
    $display("test swap and skip done");
    reg_write(REG_TBL_LOWER, 8'hFF);
    reg_write(REG_TBL_UPPER, 8'h02);
    tfetch(IXS_OP_PAGE_TABLE_FETCH, 12'h2FF);
    tfetch(IXS_OP_FINAL_PAGE_TABLE_FETCH, 12'hFFF);
    tfetch(IXS_OP_PREINC_PAGE_TABLE_FETCH, 12'h200);
    reg_read(REG_TBL_LOWER, r);
    `CHK(r, 8'h00)
    reg_read(REG_TBL_UPPER, r);
    `CHK(r, 8'h02)
    tfetch(IXS_OP_PREINC_FINAL_PAGE_TABLE_FETCH, 12'hF01);
    reg_read(REG_TBL_LATCH, r);
    `CHK(r, el_e)
    $display("test table fetch done");
    reg_write(REG_ACCUM, 8'h5A);
    run(IXS_OP_EXCLUSIVE_OR_TO_ACCUM, 8'h15, 3'h0, 8'h5A, 8'h5A, 8'h00, 1'b1, 1'b0);
    reg_read(REG_STATUS, r);
    `CHK(r[STAT_ZERO_BIT], 1'b1)
    reg_write(REG_ACCUM, 8'h0F);
    run(IXS_OP_EXCLUSIVE_OR_TO_ACCUM, 8'h15, 3'h0, 8'hF0, 8'hF0, 8'hFF, 1'b0, 1'b0);
    reg_write(REG_ACCUM, 8'h0F);
    run(IXS_OP_EXCLUSIVE_OR_TO_MEMORY, 8'h16, 3'h0, 8'hF0, 8'hFF, 8'h0F, 1'b0, 1'b0);
    run(IXS_OP_EXCLUSIVE_OR_TO_MEMORY, 8'h16, 3'h0, 8'h0F, 8'h00, 8'h0F, 1'b1, 1'b0);
    run(IXS_OP_NIBBLE_EXCHANGE_IN_PLACE, 8'h17, 3'h0, 8'h12, 8'h21, 8'h0F, 1'b1, 1'b0);
    $display("test xor done");
    finish_test();
  end
endmodule
`default_nettype wire
